//--- design/rsv_channel.sv
// one DAC channel: level policy, zero cross timeout and auto-mute
`default_nettype none
module rsv_channel #(
    parameter int SW         = 24,
    parameter int STATIC_LEN = rsv_pkg::STATIC_RUN,
    parameter int TMO_LEN    = rsv_pkg::ZC_TMO_MIN
) (
    // clock and reset
    input  wire logic          mclk,
    input  wire logic          rst_b,
    input  wire logic          ce,
    // control
    input  wire logic [1:0]    policy,
    input  wire logic [9:0]    level_req,
    input  wire logic          mute_req,
    input  wire logic          am_en,
    // audio timing and data
    input  wire logic          sample_stb,
    input  wire logic          frame_stb,
    input  wire logic [SW-1:0] sample,
    // results
    output logic      [9:0]    level,
    output logic               auto_muted
);
    typedef struct packed
    {
        logic [9:0]    level;
        logic [9:0]    tmo;
        logic [2:0]    fcnt;
        logic [13:0]   run;
        logic [SW-1:0] prev;
    } rsv_chan_state_t;

    rsv_chan_state_t st;
    rsv_chan_state_t next_st;
    logic [9:0]      target;
    logic            at_zc;
    logic            stat;

    initial
    begin
        if (SW < 2 || STATIC_LEN < 2 || STATIC_LEN > 16383 || TMO_LEN < 1 || TMO_LEN > 1023)
            $error("rsv_channel: unsupported parameter");
    end

    assign auto_muted = am_en && (st.run >= 14'(STATIC_LEN));
    assign target     = (mute_req || auto_muted) ? rsv_pkg::MUTE_LVL : level_req;
    assign level      = st.level;

    // zero crossing: a zero sample or a sign flip; timeout caps the wait
    assign at_zc = sample_stb && ((sample == '0) || (sample[SW-1] != st.prev[SW-1])
                   || (st.tmo == 10'(TMO_LEN - 1)));
    // static: 0 or -1, continuing the same value as the run so far
    assign stat  = ((sample == '0) || (&sample)) && ((st.run == '0) || (sample == st.prev));

    always_comb
    begin
        next_st = st;
        if (sample_stb)
        begin
            next_st.prev = sample;
            // the run restarts on any breaking sample, releasing the mute at once
            if (am_en && stat)
                next_st.run = (st.run >= 14'(STATIC_LEN)) ? st.run : st.run + 14'h0001;
            else
                next_st.run = '0;
        end
        if (frame_stb)
            next_st.fcnt = (st.fcnt == 3'(rsv_pkg::STEP_FRAMES - 1)) ? 3'h0 : st.fcnt + 3'h1;
        if (st.level == target)
            next_st.tmo = '0;
        else if (sample_stb)
            next_st.tmo = at_zc ? 10'h000 : st.tmo + 10'h001;
        case (rsv_pkg::rsv_policy_t'(policy))
            rsv_pkg::POL_IMMED:
                next_st.level = target;
            rsv_pkg::POL_ZC:
                if (at_zc)
                    next_st.level = target;
            rsv_pkg::POL_RAMP:
                if (frame_stb && st.fcnt == 3'(rsv_pkg::STEP_FRAMES - 1) && st.level != target)
                    next_st.level = (st.level < target) ? st.level + 10'h001
                                                        : st.level - 10'h001;
            default:
                if (at_zc && st.level != target)
                    next_st.level = (st.level < target) ? st.level + 10'h001
                                                        : st.level - 10'h001;
        endcase
    end

    // ce low freezes every counter and the level
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
            st <= '0;
        else if (ce)
            st <= next_st;
    end
endmodule
`default_nettype wire

//--- design/rsv_pkg.sv
// constants, register map and carrier types of the receiver status and level ramp block
`default_nettype none
package rsv_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_RATIO     = 8'h07;
    localparam logic [7:0] IDX_STATUS    = 8'h08;
    localparam logic [7:0] IDX_PRE0      = 8'h09;
    localparam logic [7:0] IDX_PRE3      = 8'h0C;
    localparam logic [7:0] IDX_LVL_CTRL  = 8'h0D;
    localparam logic [7:0] IDX_SILENCE   = 8'h0E;
    // level_transition_control fields
    localparam int         CTL_SHARED    = 6;
    localparam int         CTL_POL_LO    = 4;
    localparam int         CTL_ZRMUTE    = 3;
    localparam int         CTL_AUX       = 2;
    localparam int         CTL_RAMP_UP   = 1;
    localparam int         CTL_RAMP_DN   = 0;
    localparam logic [7:0] CTL_RESET     = 8'h08;
    localparam logic [7:0] SILENCE_RESET = 8'h00;
    // receiver_status fields
    localparam int         ST_SILENT     = 7;
    localparam int         ST_FMT_LO     = 4;
    localparam int         ST_SRC        = 3;
    // timing counts
    localparam int         SILENCE_RUN   = 1548;
    localparam int         STATIC_RUN    = 8192;
    localparam int         ZC_TMO_MIN    = 512;
    localparam int         STEPS_PER_DB  = 8;
    localparam int         FRAMES_PER_DB = 8;
    localparam int         STEP_FRAMES   = FRAMES_PER_DB / STEPS_PER_DB;
    // level in 1/8 dB attenuation; all ones is the quiescent mute
    localparam logic [9:0] MUTE_LVL      = 10'h3FF;
    // recovered clock frequencies for codes 0..7
    localparam logic [7:0][31:0] FREQ_HZ = {
        32'h02EE_0000, 32'h02B1_0E00, 32'h0177_0000, 32'h0158_8800,
        32'h00FA_0000, 32'h00BB_8000, 32'h00AC_4400, 32'h007D_0000};

    typedef enum logic [1:0]
    {
        POL_IMMED = 2'b00,
        POL_ZC    = 2'b01,
        POL_RAMP  = 2'b10,
        POL_RAMPZ = 2'b11
    } rsv_policy_t;

    // report from the receiver front end, same clock
    typedef struct packed
    {
        logic        ratio_valid;
        logic [7:0]  ratio;
        logic        fmt_valid;
        logic [2:0]  fmt;
        logic        src_ref;
        logic        word_valid;
        logic        word_zero;
        logic        burst_valid;
        logic [15:0] burst_type_word;
        logic [15:0] burst_length_word;
    } rsv_rx_report_t;

    typedef struct packed
    {
        logic [7:0]       ratio;
        logic             src_ref;
        logic [2:0]       fmt;
        logic [10:0]      sil_cnt;
        logic [3:0][7:0]  pre;
        logic [7:0]       ctrl;
        logic [7:0]       silence;
        logic             mode_mute;
        logic             fast;
        logic             wr_pend;
        logic [7:0]       wr_idx;
        logic [31:0]      hrdata;
    } rsv_top_state_t;
endpackage
`default_nettype wire

//--- design/rsv_top.sv
// receiver status registers and DAC level transition control behind an AHB-Lite slave
//
// Added by the designer: the AHB-Lite interface to the registers.
`default_nettype none
module rsv_top #(
    parameter int      NCH        = 8,
    parameter int      SW         = 24,
    parameter longint  REF_HZ     = 64'd24576000,
    parameter int      STATIC_LEN = rsv_pkg::STATIC_RUN,
    parameter int      TMO_LEN    = rsv_pkg::ZC_TMO_MIN
) (
    // clock, reset, enable
    input  wire logic                    mclk,
    input  wire logic                    rst_b,
    input  wire logic                    ce,
    // ahb-lite slave
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic      [31:0]             hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    // receiver front end
    input  wire rsv_pkg::rsv_rx_report_t rx,
    input  wire logic                    force_lock_enable,
    output logic                         rate_detect_enable,
    // audio
    input  wire logic                    sample_stb,
    input  wire logic                    frame_stb,
    input  wire logic [NCH-1:0][SW-1:0]  dac_sample,
    input  wire logic [NCH-1:0][7:0]     channel_volume,
    // mode change events
    input  wire logic                    mode_change_request,
    input  wire logic                    mode_change_done,
    // level results
    output logic      [NCH-1:0][9:0]     dac_level,
    output logic      [NCH-1:0]          channel_quiescent,
    output logic                         mode_mute_reached,
    output logic                         mute_indicator_pin,
    output logic                         aux_port_silence
);
    rsv_pkg::rsv_top_state_t st;
    rsv_pkg::rsv_top_state_t next_st;
    logic [NCH-1:0]          auto_muted;
    logic [6:0]              above;
    logic [2:0]              freq_code;
    logic [1:0]              pol_eff;
    logic                    take;
    logic [7:0]              addr_idx;
    logic                    addr_ok;
    logic [7:0]              fwd_ctrl;
    logic [7:0]              fwd_sil;

    initial
    begin
        if (NCH < 1 || NCH > 8 || SW < 2 || REF_HZ < 1)
            $error("rsv_top: unsupported parameter");
    end

    // ratio above a midpoint means the recovered clock is below it
    for (genvar k = 0; k < 7; k++)
    begin : g_thr
        localparam longint MID2 = longint'(rsv_pkg::FREQ_HZ[k])
                                  + longint'(rsv_pkg::FREQ_HZ[k+1]);
        assign above[k] = (REF_HZ * 128) > (MID2 * longint'(st.ratio));
    end

    // code is how many midpoints the recovered clock lies above; force lock makes it 7
    always_comb
    begin
        freq_code = 3'h0;
        for (int k = 0; k < 7; k++)
            freq_code = freq_code + 3'(above[k]);
        if (force_lock_enable)
            freq_code = 3'h7;
    end

    // ahb address phase decode
    assign take     = hsel && hready && htrans[1];
    assign addr_idx = haddr[9:2];
    assign addr_ok  = (haddr[31:10] == 22'h0) && (haddr[1:0] == 2'b00);

    // a read right behind a write sees the written value
    assign fwd_ctrl = (st.wr_pend && st.wr_idx == rsv_pkg::IDX_LVL_CTRL) ? hwdata[7:0]
                                                                          : st.ctrl;
    assign fwd_sil  = (st.wr_pend && st.wr_idx == rsv_pkg::IDX_SILENCE) ? hwdata[7:0]
                                                                         : st.silence;

    function automatic logic [7:0] read_reg(input logic [7:0] idx, input logic [2:0] fc,
                                            input logic [7:0] ctl, input logic [7:0] sil);
        logic [7:0] r;
        r = 8'h00;
        if (idx == rsv_pkg::IDX_RATIO)
            r = st.ratio;
        else if (idx == rsv_pkg::IDX_STATUS)
            r = {st.sil_cnt >= 11'(rsv_pkg::SILENCE_RUN), st.fmt, st.src_ref, fc};
        else if (idx >= rsv_pkg::IDX_PRE0 && idx <= rsv_pkg::IDX_PRE3)
            r = st.pre[2'(idx - rsv_pkg::IDX_PRE0)];
        else if (idx == rsv_pkg::IDX_LVL_CTRL)
            r = {1'b0, ctl[6:0]};
        else if (idx == rsv_pkg::IDX_SILENCE)
            r = sil;
        return r;
    endfunction

    always_comb
    begin
        next_st = st;
        // receiver report capture; ratio frozen while force lock holds
        if (rx.ratio_valid && !force_lock_enable)
            next_st.ratio = rx.ratio;
        next_st.src_ref = rx.src_ref;
        if (rx.fmt_valid)
            next_st.fmt = rx.fmt;
        if (rx.word_valid)
        begin
            if (!rx.word_zero)
                next_st.sil_cnt = '0;
            else if (st.sil_cnt < 11'(rsv_pkg::SILENCE_RUN))
                next_st.sil_cnt = st.sil_cnt + 11'h001;
        end
        if (rx.burst_valid)
            next_st.pre = {rx.burst_length_word, rx.burst_type_word};
        // mode mute: request mutes, done un-mutes; fast skips the policy
        if (mode_change_request)
        begin
            next_st.mode_mute = 1'b1;
            next_st.fast      = !st.ctrl[rsv_pkg::CTL_RAMP_DN];
        end
        else if (mode_change_done)
        begin
            next_st.mode_mute = 1'b0;
            next_st.fast      = !st.ctrl[rsv_pkg::CTL_RAMP_UP];
        end
        // data phase of a write; only the two writable registers take it
        if (st.wr_pend)
        begin
            if (st.wr_idx == rsv_pkg::IDX_LVL_CTRL)
                next_st.ctrl = {1'b0, hwdata[6:0]};
            else if (st.wr_idx == rsv_pkg::IDX_SILENCE)
                next_st.silence = hwdata[7:0];
        end
        // address phase; read-only and unmapped writes never pend
        next_st.wr_pend = 1'b0;
        if (take)
        begin
            if (hwrite)
            begin
                next_st.wr_pend = addr_ok && (addr_idx == rsv_pkg::IDX_LVL_CTRL
                                  || addr_idx == rsv_pkg::IDX_SILENCE);
                next_st.wr_idx  = addr_idx;
            end
            else
                next_st.hrdata = addr_ok ? {24'h0, read_reg(addr_idx, freq_code, fwd_ctrl,
                                                            fwd_sil)} : 32'h0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            st         <= '0;
            st.ctrl    <= rsv_pkg::CTL_RESET;
            st.silence <= rsv_pkg::SILENCE_RESET;
        end
        else if (ce)
            st <= next_st;
    end

    // zero wait, always OKAY
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = st.hrdata;

    assign rate_detect_enable = !force_lock_enable;
    assign aux_port_silence   = st.ctrl[rsv_pkg::CTL_AUX];
    assign mute_indicator_pin = |auto_muted;
    assign pol_eff = st.fast ? 2'b00 : st.ctrl[rsv_pkg::CTL_POL_LO +: 2];

    for (genvar i = 0; i < NCH; i++)
    begin : g_ch
        logic [7:0] vol;
        logic [9:0] lvl_req;
        // shared level reads the first channel's volume for all
        assign vol = st.ctrl[rsv_pkg::CTL_SHARED] ? channel_volume[0]
                                                  : channel_volume[i];
        // 0.5 dB code to 1/8 dB; codes past -127 dB equal mute
        assign lvl_req = (vol == 8'hFF) ? rsv_pkg::MUTE_LVL : {vol, 2'b00};

        rsv_channel #(
            .SW         (SW),
            .STATIC_LEN (STATIC_LEN),
            .TMO_LEN    (TMO_LEN)
        ) u_ch (
            .mclk       (mclk),
            .rst_b      (rst_b),
            .ce         (ce),
            .policy     (pol_eff),
            .level_req  (lvl_req),
            .mute_req   (st.silence[i] || st.mode_mute),
            .am_en      (st.ctrl[rsv_pkg::CTL_ZRMUTE]),
            .sample_stb (sample_stb),
            .frame_stb  (frame_stb),
            .sample     (dac_sample[i]),
            .level      (dac_level[i]),
            .auto_muted (auto_muted[i])
        );
        assign channel_quiescent[i] = (dac_level[i] == rsv_pkg::MUTE_LVL);
    end

    assign mode_mute_reached = st.mode_mute && (&channel_quiescent);
endmodule
`default_nettype wire

//--- testbench/receiver_status_and_volume_ramp_tb.sv
// register and level sequences against the receiver status and level block
`default_nettype none
module receiver_status_and_volume_ramp_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int NCH = 8;
    logic mclk, rst_b, ce, hsel, hwrite, hreadyout, hresp, tmo;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    rsv_pkg::rsv_rx_report_t rx;
    logic force_lock_enable, rate_detect_enable, sample_stb, frame_stb;
    logic mode_change_request, mode_change_done, mode_mute_reached;
    logic mute_indicator_pin, aux_port_silence;
    logic [NCH-1:0][23:0] dac_sample;
    logic [NCH-1:0][7:0] channel_volume;
    logic [NCH-1:0][9:0] dac_level;
    logic [NCH-1:0] channel_quiescent;
    int n_fail = 0;
    int compares = 0;
    logic [7:0] rt [5] = '{8'hC0, 8'h8B, 8'h60, 8'h40, 8'h20};
    logic [2:0] cd [5] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h7};
    logic [7:0] pb [4] = '{8'hB2, 8'hA1, 8'hD4, 8'hC3};
    always #5 mclk = ~mclk;
    rsv_top #(.STATIC_LEN(8), .TMO_LEN(4)) DUT (.mclk(mclk), .rst_b(rst_b), .ce(ce),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .rx(rx), .force_lock_enable(force_lock_enable),
        .rate_detect_enable(rate_detect_enable), .sample_stb(sample_stb),
        .frame_stb(frame_stb), .dac_sample(dac_sample), .channel_volume(channel_volume),
        .mode_change_request(mode_change_request), .mode_change_done(mode_change_done),
        .dac_level(dac_level), .channel_quiescent(channel_quiescent),
        .mode_mute_reached(mode_mute_reached), .mute_indicator_pin(mute_indicator_pin),
        .aux_port_silence(aux_port_silence));
    rsv_host_model h (.mclk(mclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .tmo(tmo));
    task automatic final_report();
        if (n_fail == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge tmo)
    begin
        n_fail++;
        final_report();
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e)
        begin
            n_fail++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic rs(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] d;
        h.rd(a, d);
        chk(d & m, e);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // n sample or frame strobes, each followed by an idle cycle
    task automatic tick(input int n, input logic f);
        repeat (n)
        begin
            sample_stb <= !f;
            frame_stb <= f;
            cyc(1);
            sample_stb <= 1'b0;
            frame_stb <= 1'b0;
            cyc(1);
        end
    endtask
    task automatic lvl(input int c, input logic [9:0] e);
        chk({22'h0, dac_level[c]}, {22'h0, e});
    endtask
    initial
    begin
        mclk = 1'b0;
        rst_b = 1'b0;
        ce = 1'b1;
        rx = '0;
        force_lock_enable = 1'b0;
        {sample_stb, frame_stb, mode_change_request, mode_change_done} = 4'h0;
        dac_sample = {NCH{24'h000100}};
        for (int i = 0; i < NCH; i++)
            channel_volume[i] = 8'(4 * i + 4);
        cyc(6);
        rst_b <= 1'b1;
        cyc(1);
        rs(32'h34, 32'hFFFFFFFF, {24'h0, rsv_pkg::CTL_RESET});
        rs(32'h38, 32'hFFFFFFFF, 32'h0);
        for (int i = 0; i < 5; i++)
        begin
            rx.ratio <= rt[i];
            rx.ratio_valid <= 1'b1;
            cyc(1);
            rx.ratio_valid <= 1'b0;
            rs(32'h1C, 32'hFF, {24'h0, rt[i]});
            rs(32'h20, 32'h07, {29'h0, cd[i]});
        end
        for (int i = 0; i < 8; i++)
        begin
            rx.fmt <= 3'(i);
            rx.src_ref <= i[0];
            rx.fmt_valid <= 1'b1;
            cyc(1);
            rx.fmt_valid <= 1'b0;
            rs(32'h20, 32'h78, {25'h0, 3'(i), i[0], 3'h0});
        end
        force_lock_enable <= 1'b1;
        cyc(1);
        chk({31'h0, rate_detect_enable}, 32'h0);
        rs(32'h20, 32'h07, 32'h7);
        force_lock_enable <= 1'b0;
        // zero run one short of the limit, completed, broken, then restarted
        rx.word_zero <= 1'b1;
        rx.word_valid <= 1'b1;
        cyc(rsv_pkg::SILENCE_RUN - 1);
        rx.word_valid <= 1'b0;
        rs(32'h20, 32'h80, 32'h0);
        rx.word_valid <= 1'b1;
        cyc(1);
        rx.word_valid <= 1'b0;
        rs(32'h20, 32'h80, 32'h80);
        rx.word_zero <= 1'b0;
        rx.word_valid <= 1'b1;
        cyc(1);
        rx.word_zero <= 1'b1;
        cyc(rsv_pkg::SILENCE_RUN - 1);
        rx.word_valid <= 1'b0;
        rs(32'h20, 32'h80, 32'h0);
        rx.burst_type_word <= 16'hA1B2;
        rx.burst_length_word <= 16'hC3D4;
        rx.burst_valid <= 1'b1;
        cyc(1);
        rx.burst_valid <= 1'b0;
        for (int i = 0; i < 4; i++)
            rs(32'(36 + 4 * i), 32'hFF, {24'h0, pb[i]});
        h.wr(32'h1C, 32'hFF);
        h.wr(32'h24, 32'h00);
        rs(32'h1C, 32'hFF, 32'h20);
        rs(32'h24, 32'hFF, 32'hB2);
        rs(32'h0, 32'hFFFFFFFF, 32'h0);
        h.wr(32'h34, 32'hFF);
        rs(32'h34, 32'hFFFFFFFF, 32'h7F);
        chk({31'h0, aux_port_silence}, 32'h1);
        h.wr(32'h34, 32'h48);
        cyc(2);
        chk({31'h0, aux_port_silence}, 32'h0);
        for (int i = 0; i < NCH; i++)
            lvl(i, 10'h010);
        h.wr(32'h34, 32'h08);
        cyc(2);
        for (int i = 0; i < NCH; i++)
            lvl(i, 10'(16 * i + 16));
        h.wr(32'h38, 32'h01);
        cyc(2);
        lvl(0, 10'h3FF);
        lvl(1, 10'h020);
        h.wr(32'h38, 32'h00);
        cyc(2);
        lvl(0, 10'h010);
        // zero cross: held off, taken on a sign flip, then by timeout
        h.wr(32'h34, 32'h18);
        channel_volume[1] <= 8'h20;
        tick(1, 1'b0);
        lvl(1, 10'h020);
        dac_sample[1] <= 24'hFFFF00;
        tick(1, 1'b0);
        cyc(1);
        lvl(1, 10'h080);
        channel_volume[1] <= 8'h10;
        tick(8, 1'b0);
        cyc(1);
        lvl(1, 10'h040);
        h.wr(32'h34, 32'h28);
        channel_volume[1] <= 8'h11;
        cyc(2);
        tick(2, 1'b1);
        lvl(1, 10'h042);
        tick(3, 1'b1);
        lvl(1, 10'h044);
        h.wr(32'h34, 32'h38);
        channel_volume[1] <= 8'h12;
        cyc(2);
        dac_sample[1] <= 24'h000100;
        tick(1, 1'b0);
        cyc(1);
        lvl(1, 10'h045);
        h.wr(32'h34, 32'h08);
        dac_sample[2] <= 24'h0;
        tick(7, 1'b0);
        chk({31'h0, mute_indicator_pin}, 32'h0);
        tick(1, 1'b0);
        cyc(1);
        chk({31'h0, mute_indicator_pin}, 32'h1);
        lvl(2, 10'h3FF);
        lvl(3, 10'h040);
        dac_sample[2] <= 24'h000005;
        tick(1, 1'b0);
        cyc(1);
        chk({31'h0, mute_indicator_pin}, 32'h0);
        lvl(2, 10'h030);
        mode_change_request <= 1'b1;
        cyc(1);
        mode_change_request <= 1'b0;
        cyc(2);
        chk({31'h0, mode_mute_reached}, 32'h1);
        lvl(0, 10'h3FF);
        mode_change_done <= 1'b1;
        cyc(1);
        mode_change_done <= 1'b0;
        cyc(2);
        lvl(0, 10'h010);
        // ramped mode mute and un-mute; ce low must freeze the ramp before its first step
        h.wr(32'h34, 32'h2B);
        chk({31'h0, hresp}, 32'h0);
        mode_change_request <= 1'b1;
        cyc(1);
        mode_change_request <= 1'b0;
        cyc(2);
        lvl(0, 10'h010);
        ce <= 1'b0;
        tick(1, 1'b1);
        lvl(0, 10'h010);
        ce <= 1'b1;
        tick(1, 1'b1);
        lvl(0, 10'h011);
        chk({31'h0, mode_mute_reached}, 32'h0);
        mode_change_done <= 1'b1;
        cyc(1);
        mode_change_done <= 1'b0;
        tick(1, 1'b1);
        lvl(0, 10'h010);
        final_report();
    end
endmodule
bind rsv_top rsv_top_chk #(.NCH(NCH)) u_chk (.mclk(mclk), .rst_b(rst_b), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .force_lock_enable(force_lock_enable),
    .rate_detect_enable(rate_detect_enable), .dac_level(dac_level),
    .channel_quiescent(channel_quiescent), .mode_mute_reached(mode_mute_reached),
    .aux_port_silence(aux_port_silence));
`default_nettype wire

//--- testbench/rsv_host_model.sv
// ahb-lite master standing in for the host controller
`default_nettype none
module rsv_host_model (
    // clock and answer
    input  wire logic        mclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    // request
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata,
    // a wait ran out
    output logic             tmo
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        tmo = 1'b0;
    end
    // next edge with hready high; bounded so a stuck slave cannot hang us
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge mclk);
        while (hready !== 1'b1 && n < 16)
        begin
            n++;
            @(posedge mclk);
        end
        if (n == 16)
            tmo <= 1'b1;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        haddr <= a;
        hwrite <= 1'b1;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        hwdata <= ~d;   // released data must not keep the last value
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        haddr <= a;
        hwrite <= 1'b0;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        wait_rdy();
        d = hrdata;
    endtask
endmodule
`default_nettype wire

//--- testbench/rsv_top_assertions.sv
// concurrent checks on the ports of the receiver status and level block
`default_nettype none
module rsv_top_chk #(
    parameter int NCH = 8
) (
    // clock, reset, enable
    input wire logic                mclk,
    input wire logic                rst_b,
    input wire logic                ce,
    // bus
    input wire logic                hsel,
    input wire logic [31:0]         haddr,
    input wire logic [1:0]          htrans,
    input wire logic                hwrite,
    input wire logic [31:0]         hwdata,
    input wire logic                hready,
    input wire logic [31:0]         hrdata,
    // status and levels
    input wire logic                force_lock_enable,
    input wire logic                rate_detect_enable,
    input wire logic [NCH-1:0][9:0] dac_level,
    input wire logic [NCH-1:0]      channel_quiescent,
    input wire logic                mode_mute_reached,
    input wire logic                aux_port_silence
);
    timeunit 1ns;
    timeprecision 1ps;
    // accepted address phase, and its read flavour
    wire logic req = hsel && hready && htrans[1] && ce;
    wire logic rdq = req && !hwrite;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    a_detect_off: assert property (rate_detect_enable == !force_lock_enable)
        else $error("rate detect not inverse of force lock");
    a_aux_write: assert property (req && hwrite && haddr == 32'h34
        |-> ##2 aux_port_silence == $past(hwdata[2])) else $error("aux silence not written");
    a_ctrl_top_zero: assert property (rdq && haddr == 32'h34 |=> hrdata[31:7] == 25'h0)
        else $error("control reserved bits not zero");
    a_unmapped_zero: assert property (rdq && haddr == 32'h0 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_force_code: assert property (rdq && haddr == 32'h20 && force_lock_enable
        |=> hrdata[2:0] == 3'h7) else $error("forced lock code not all ones");
    // read data stands until the next read address phase
    a_data_holds: assert property (!rdq |=> $stable(hrdata))
        else $error("read data moved without a read");
    a_quiet_flag: assert property (channel_quiescent[0] == (dac_level[0] == 10'h3FF))
        else $error("quiescent flag wrong");
    a_mode_all_quiet: assert property (mode_mute_reached |-> &channel_quiescent)
        else $error("mode mute reported before all channels quiet");
endmodule
`default_nettype wire
